/* rtl/updown_pkg.sv */
// Purpose: Shared constants for the 16-bit up/down event counter with serial readout
// Assumes: 50 MHz system clock, all pins asynchronous to it
// Notes:   Byte addresses on the register bus, one aligned 32-bit word per register
package updown_pkg;

    // ========================================================================
    // Widths
    // ========================================================================
    localparam int CELL_W    = 8;
    localparam int COUNT_W   = 16;
    localparam int AV_ADDR_W = 4;
    localparam int AV_DATA_W = 32;
    localparam int AV_BE_W   = 4;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam logic [AV_ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [AV_ADDR_W-1:0] OFS_COUNT  = 4'h4;
    localparam logic [AV_ADDR_W-1:0] OFS_STATUS = 4'h8;

    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_DSEL_BIT  = 1;
    localparam int CTRL_SWDIR_BIT = 2;
    localparam int CTRL_CLR_BIT   = 3;
    localparam int CTRL_BE_BIT    = 0;

    localparam int ST_DIR_BIT  = 0;
    localparam int ST_TERM_BIT = 1;
    localparam int ST_SEL_BIT  = 2;
    localparam int ST_RST_BIT  = 3;

    localparam logic CTRL_EN_RST    = 1'b1;
    localparam logic CTRL_DSEL_RST  = 1'b0;
    localparam logic CTRL_SWDIR_RST = 1'b1;

    localparam logic [AV_DATA_W-1:0] RDATA_NONE = 32'h0000_0000;

    // ========================================================================
    // Pin vector layout
    // ========================================================================
    localparam int PIN_W     = 5;
    localparam int PIN_CNT   = 0;
    localparam int PIN_DIR   = 1;
    localparam int PIN_RST   = 2;
    localparam int PIN_SCLK  = 3;
    localparam int PIN_CSN   = 4;
    // Idle levels: chip select high, everything else low
    localparam logic [PIN_W-1:0] PIN_IDLE = 5'h10;

endpackage

/* rtl/count_cell.sv */
// Purpose: One counting cell: increment, decrement or hold on each step
// Assumes: step is a one-cycle enable on clk
// Notes:   Wraps freely at both ends; clear has priority over step
`timescale 1ns/10ps
module count_cell #(
    parameter int W = updown_pkg::CELL_W
) (
    input  wire logic         clk,      // System clock
    input  wire logic         rst_n,    // Asynchronous reset, active low
    input  wire logic         step,     // Counted pulse, one cycle
    input  wire logic         clear,    // Synchronous clear to zero
    input  wire logic         up,       // 1 counts up, 0 counts down
    input  wire logic         keep,     // 1 holds the value on a step
    output logic [W-1:0]      value,    // Present cell value
    output logic              terminal  // At terminal value for the direction
);

    typedef struct packed {
        logic [W-1:0] value;
    } cell_state_t;

    cell_state_t st_r;
    cell_state_t st_nxt;

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        st_nxt = st_r;
        if (clear) begin
            st_nxt.value = '0;
        end else if (step && !keep) begin
            if (up) begin
                st_nxt.value = st_r.value + W'(1);
            end else begin
                st_nxt.value = st_r.value - W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign value = st_r.value;
    assign terminal = up ? (st_r.value == {W{1'b1}}) : (st_r.value == '0);

endmodule

/* rtl/updown_counter_16bit_serial.sv */
// Purpose: 16-bit bidirectional event counter, two cascaded 8-bit cells,
//          count shifted out on a serial peripheral port and readable on Avalon-MM
// Assumes: All pins asynchronous to clk; counted pulses and serial clock are
//          much slower than clk (each level held at least three clk cycles)
// Notes:   Serial readout is mode 0, MSB first, snapshot taken at chip select fall
`timescale 1ns/10ps
module updown_counter_16bit_serial (
    input  wire logic                               clk,             // System clock, 50 MHz
    input  wire logic                               rst_n,           // Async reset, active low
    input  wire logic                               count_clk_pin,   // Counted pulses
    input  wire logic                               count_up_pin,    // Direction, high is up
    input  wire logic                               count_rst_pin,   // Count clear, high
    input  wire logic                               spi_sclk,        // Serial clock from host
    input  wire logic                               spi_cs_n,        // Chip select, active low
    output logic                                    spi_miso,        // Serial data to host
    output logic                                    spi_miso_oe,     // Drive enable for miso
    output logic [updown_pkg::COUNT_W-1:0]          count,           // Running count
    input  wire logic [updown_pkg::AV_ADDR_W-1:0]   avs_address,     // Byte address
    input  wire logic                               avs_read,        // Read request
    input  wire logic                               avs_write,       // Write request
    input  wire logic [updown_pkg::AV_DATA_W-1:0]   avs_writedata,   // Write data
    input  wire logic [updown_pkg::AV_BE_W-1:0]     avs_byteenable,  // Byte enables
    output logic [updown_pkg::AV_DATA_W-1:0]        avs_readdata,    // Read data
    output logic                                    avs_waitrequest  // Stall, high
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic [updown_pkg::PIN_W-1:0]     meta;
        logic [updown_pkg::PIN_W-1:0]     sync;
        logic [updown_pkg::PIN_W-1:0]     prev;
        logic                             count_en;
        logic                             dir_sel;
        logic                             sw_dir;
        logic                             sw_clear;
        logic                             waitreq;
        logic [updown_pkg::AV_DATA_W-1:0] rdata;
        logic [updown_pkg::COUNT_W-1:0]   shift;
        logic                             miso;
        logic                             miso_oe;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;

    logic [updown_pkg::PIN_W-1:0]   pins;
    logic [updown_pkg::CELL_W-1:0]  upper_value;
    logic [updown_pkg::CELL_W-1:0]  lower_value;
    logic                           lower_terminal;
    logic                           step;
    logic                           clear;
    logic                           dir_up;
    logic                           cs_fall;
    logic                           sclk_fall;
    logic                           spi_sel;
    logic [updown_pkg::COUNT_W-1:0] count_now;

    // ========================================================================
    // Pin gathering
    // ========================================================================
    always_comb begin
        pins = '0;
        pins[updown_pkg::PIN_CNT]  = count_clk_pin;
        pins[updown_pkg::PIN_DIR]  = count_up_pin;
        pins[updown_pkg::PIN_RST]  = count_rst_pin;
        pins[updown_pkg::PIN_SCLK] = spi_sclk;
        pins[updown_pkg::PIN_CSN]  = spi_cs_n;
    end

    // ========================================================================
    // Decoded events, all from the second synchroniser stage onward
    // ========================================================================
    // one step for both cells
    assign step = st_r.count_en
                  && st_r.sync[updown_pkg::PIN_CNT]
                  && !st_r.prev[updown_pkg::PIN_CNT];

    assign clear = st_r.sync[updown_pkg::PIN_RST] || st_r.sw_clear;

    assign dir_up = st_r.dir_sel ? st_r.sw_dir : st_r.sync[updown_pkg::PIN_DIR];

    assign spi_sel   = !st_r.sync[updown_pkg::PIN_CSN];
    assign cs_fall   = st_r.prev[updown_pkg::PIN_CSN] && spi_sel;
    assign sclk_fall = spi_sel
                       && st_r.prev[updown_pkg::PIN_SCLK]
                       && !st_r.sync[updown_pkg::PIN_SCLK];

    assign count_now = {upper_value, lower_value};

    // ========================================================================
    // Counting cells
    // ========================================================================
    // lower cell changes on every step
    count_cell #(
        .W        (updown_pkg::CELL_W)
    ) lower_count_cell (
        .clk      (clk),
        .rst_n    (rst_n),
        .step     (step),
        .clear    (clear),
        .up       (dir_up),
        .keep     (1'b0),
        .value    (lower_value),
        .terminal (lower_terminal)
    );

    // upper held unless lower is terminal
    count_cell #(
        .W        (updown_pkg::CELL_W)
    ) upper_count_cell (
        .clk      (clk),
        .rst_n    (rst_n),
        .step     (step),
        .clear    (clear),
        .up       (dir_up),
        .keep     (!lower_terminal),
        .value    (upper_value),
        .terminal ()
    );

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        st_nxt = st_r;

        // Two-stage synchroniser, then one stage for edge finding
        st_nxt.meta = pins;
        st_nxt.sync = st_r.meta;
        st_nxt.prev = st_r.sync;

        // Software clear lasts one cycle
        st_nxt.sw_clear = 1'b0;

        // --------------------------------------------------------------------
        // Register bus: answer one cycle after the request is seen
        // --------------------------------------------------------------------
        if (!st_r.waitreq) begin
            st_nxt.waitreq = 1'b1;
            if (avs_write && avs_address == updown_pkg::OFS_CTRL
                && avs_byteenable[updown_pkg::CTRL_BE_BIT]) begin
                st_nxt.count_en = avs_writedata[updown_pkg::CTRL_EN_BIT];
                st_nxt.dir_sel  = avs_writedata[updown_pkg::CTRL_DSEL_BIT];
                st_nxt.sw_dir   = avs_writedata[updown_pkg::CTRL_SWDIR_BIT];
                st_nxt.sw_clear = avs_writedata[updown_pkg::CTRL_CLR_BIT];
            end
        end else if (avs_read || avs_write) begin
            st_nxt.waitreq = 1'b0;
            st_nxt.rdata   = updown_pkg::RDATA_NONE;
            if (avs_read) begin
                if (avs_address == updown_pkg::OFS_CTRL) begin
                    st_nxt.rdata[updown_pkg::CTRL_EN_BIT]    = st_r.count_en;
                    st_nxt.rdata[updown_pkg::CTRL_DSEL_BIT]  = st_r.dir_sel;
                    st_nxt.rdata[updown_pkg::CTRL_SWDIR_BIT] = st_r.sw_dir;
                end else if (avs_address == updown_pkg::OFS_COUNT) begin
                    st_nxt.rdata[updown_pkg::COUNT_W-1:0] = count_now;
                end else if (avs_address == updown_pkg::OFS_STATUS) begin
                    st_nxt.rdata[updown_pkg::ST_DIR_BIT]  = dir_up;
                    st_nxt.rdata[updown_pkg::ST_TERM_BIT] = lower_terminal;
                    st_nxt.rdata[updown_pkg::ST_SEL_BIT]  = spi_sel;
                    st_nxt.rdata[updown_pkg::ST_RST_BIT]  =
                        st_r.sync[updown_pkg::PIN_RST];
                end
            end
        end

        // --------------------------------------------------------------------
        // Serial readout
        // --------------------------------------------------------------------
        // snapshot so both bytes belong together
        if (cs_fall) begin
            st_nxt.shift   = count_now;
            st_nxt.miso    = count_now[updown_pkg::COUNT_W-1];
            st_nxt.miso_oe = 1'b1;
        end else if (!spi_sel) begin
            st_nxt.miso_oe = 1'b0;
            st_nxt.miso    = 1'b0;
        end else if (sclk_fall) begin
            // next bit after falling serial clock
            st_nxt.shift = {st_r.shift[updown_pkg::COUNT_W-2:0], 1'b0};
            st_nxt.miso  = st_r.shift[updown_pkg::COUNT_W-2];
        end
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r          <= '0;
            st_r.meta     <= updown_pkg::PIN_IDLE;
            st_r.sync     <= updown_pkg::PIN_IDLE;
            st_r.prev     <= updown_pkg::PIN_IDLE;
            st_r.count_en <= updown_pkg::CTRL_EN_RST;
            st_r.dir_sel  <= updown_pkg::CTRL_DSEL_RST;
            st_r.sw_dir   <= updown_pkg::CTRL_SWDIR_RST;
            st_r.waitreq  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign spi_miso        = st_r.miso;
    assign spi_miso_oe     = st_r.miso_oe;
    assign count           = count_now;
    assign avs_readdata    = st_r.rdata;
    assign avs_waitrequest = st_r.waitreq;

endmodule

/* dv/updown_chk.sv */
// Purpose: Port checks for the up/down counter
// Assumes: Software direction never opposes a high direction pin
// Notes:   Bound to the counter
`timescale 1ns/10ps
module updown_chk (
    input wire logic                              clk,             // Clock
    input wire logic                              rst_n,           // Reset, active low
    input wire logic                              count_up_pin,    // Direction pin
    input wire logic                              count_rst_pin,   // Clear pin
    input wire logic                              spi_cs_n,        // Chip select
    input wire logic                              spi_miso,        // Serial data
    input wire logic                              spi_miso_oe,     // Serial enable
    input wire logic [updown_pkg::COUNT_W-1:0]    count,           // Count
    input wire logic [updown_pkg::AV_ADDR_W-1:0]  avs_address,     // Address
    input wire logic                              avs_read,        // Read
    input wire logic                              avs_write,       // Write
    input wire logic [updown_pkg::AV_DATA_W-1:0]  avs_readdata,    // Read data
    input wire logic                              avs_waitrequest  // Stall
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ========================================
    // Assertions
    AST_PIN_CLEAR: assert property (count_rst_pin [*4] |-> count == 16'h0000)
        else $error("count not cleared by pin");
    AST_STEP: assert property (count != $past(count) |-> count == $past(count) + 16'h0001
        || count == $past(count) - 16'h0001 || count == 16'h0000)
        else $error("count moved by more than one");
    AST_UP: assert property (count_up_pin [*4] ##0 (count != $past(count) && count != 16'h0000)
        |-> count == $past(count) + 16'h0001)
        else $error("count did not go up");
    AST_HOLD: assert property (!(count[7:0] inside {8'hFF, 8'h00})
        |=> count[15:8] == $past(count[15:8]) || count == 16'h0000)
        else $error("upper byte moved off terminal");
    AST_LOWER: assert property (count[15:8] != $past(count[15:8]) && count != 16'h0000
        |-> count[7:0] != $past(count[7:0]))
        else $error("lower byte did not step with upper");
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("bus answer late");
    AST_WAIT_PULSE: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_READ: assert property (avs_read && !avs_waitrequest && avs_address == 4'h4
        |-> avs_readdata == {16'h0000, $past(count)})
        else $error("count read mismatch");
    AST_OE_ON: assert property ($fell(spi_cs_n) |-> ##[1:4] spi_miso_oe)
        else $error("serial output not enabled");
    AST_IDLE: assert property (spi_cs_n [*4] |-> !spi_miso_oe && !spi_miso)
        else $error("serial output active while idle");
    COV_CARRY: cover property (count[15:8] != $past(count[15:8]) && count != 16'h0000);
    COV_READ: cover property (avs_read && !avs_waitrequest);
    COV_FRAME: cover property (spi_miso_oe && !spi_cs_n);
endmodule
bind updown_counter_16bit_serial updown_chk checks (.clk(clk), .rst_n(rst_n),
    .count_up_pin(count_up_pin), .count_rst_pin(count_rst_pin), .spi_cs_n(spi_cs_n),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .count(count), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

/* dv/spi_host_model.sv */
// Purpose: Host reading the count over the serial port
// Assumes: Mode 0, 160 ns serial clock
// Notes:   Clock stands low outside frames
`timescale 1ns/10ps
module spi_host_model (
    input  wire logic clk,   // System clock
    input  wire logic miso,  // Serial data in
    output logic      sclk,  // Serial clock
    output logic      cs_n   // Chip select, active low
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    task automatic frame(output logic [15:0] v);
        int i;
        v = 16'h0000;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (5) @(posedge clk);
        for (i = 0; i < 16; i++) begin
            v = {v[14:0], miso};
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        cs_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask
endmodule

/* dv/test_updown_counter_16bit_serial.sv */
// Purpose: Bench for the up/down counter
// Assumes: Software direction never opposes a high direction pin
// Notes:   Count pulses held four clocks per level
`timescale 1ns/10ps
module test_updown_counter_16bit_serial;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        count_clk_pin = 1'b0;
    logic        count_up_pin = 1'b1;
    logic        count_rst_pin = 1'b0;
    logic        spi_sclk, spi_cs_n, spi_miso, spi_miso_oe;
    logic [15:0] count, exp, sv;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest;
    int          miscompares = 0;
    int          checked = 0;

    always #10 clk = ~clk;

    updown_counter_16bit_serial dut (.clk(clk), .rst_n(rst_n), .count_clk_pin(count_clk_pin),
        .count_up_pin(count_up_pin), .count_rst_pin(count_rst_pin), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .count(count),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    // Undriven line shows the inverse, so a missing output enable corrupts the frame
    spi_host_model host (.clk(clk), .miso(spi_miso_oe ? spi_miso : !spi_miso),
        .sclk(spi_sclk), .cs_n(spi_cs_n));

    // ========================================
    // Tasks
    task automatic summarize();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            miscompares++;
            summarize();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic pulse(input logic up, input int n);
        count_up_pin <= up;
        repeat (4) @(posedge clk);
        repeat (n) begin
            count_clk_pin <= 1'b1;
            repeat (4) @(posedge clk);
            count_clk_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic cmpc();
        chk("count pins", {16'h0000, exp}, {16'h0000, count});
        bus(1'b0, 4'h4, 32'h0000_0000);
        chk("count reg", {16'h0000, exp}, rd);
    endtask
    task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask

    // ========================================
    // Sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        exp = 16'h0000;
        cmpc();
        rdchk("ctrl", 4'h0, 32'h0000_0005);
        rdchk("unmapped", 4'hC, 32'h0000_0000);
        pulse(1'b1, 3);
        exp = 16'h0003;
        cmpc();
        rdchk("status", 4'h8, 32'h0000_0001);
        host.frame(sv);
        chk("serial", {16'h0000, exp}, {16'h0000, sv});
        pulse(1'b0, 5);
        exp = 16'hFFFE;
        cmpc();
        host.frame(sv);
        chk("serial", {16'h0000, exp}, {16'h0000, sv});
        pulse(1'b1, 1);
        exp = 16'hFFFF;
        cmpc();
        rdchk("status", 4'h8, 32'h0000_0003);
        pulse(1'b1, 1);
        exp = 16'h0000;
        cmpc();
        pulse(1'b0, 0);
        rdchk("status", 4'h8, 32'h0000_0002);
        bus(1'b1, 4'h0, 32'h0000_0004);
        pulse(1'b1, 2);
        cmpc();
        avs_byteenable <= 4'h0;
        bus(1'b1, 4'h0, 32'h0000_0005);
        avs_byteenable <= 4'hF;
        rdchk("ctrl", 4'h0, 32'h0000_0004);
        bus(1'b1, 4'h0, 32'h0000_0005);
        bus(1'b1, 4'hC, 32'hFFFF_FFFF);
        rdchk("ctrl", 4'h0, 32'h0000_0005);
        pulse(1'b1, 2);
        exp = 16'h0002;
        cmpc();
        count_rst_pin <= 1'b1;
        pulse(1'b1, 1);
        exp = 16'h0000;
        cmpc();
        rdchk("status", 4'h8, 32'h0000_0009);
        count_rst_pin <= 1'b0;
        pulse(1'b1, 3);
        exp = 16'h0003;
        cmpc();
        // Software direction up while the pin says down
        bus(1'b1, 4'h0, 32'h0000_0007);
        pulse(1'b0, 2);
        exp = 16'h0005;
        cmpc();
        rdchk("status", 4'h8, 32'h0000_0001);
        bus(1'b1, 4'h0, 32'h0000_000D);
        repeat (2) @(posedge clk);
        exp = 16'h0000;
        cmpc();
        summarize();
    end
endmodule
